// ---- rtl/smrc_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Upper pair word: last input in 19-10, second last in 9-0, 23-20 zero.
// - Converter self-check value readable in bits 19-10 of diagnosis word.
// - Supply measurement readable in bits 9-0 of the diagnosis word.
// - Setup bit 23 selects supply divider: 0 gives 3, 1 gives 10.
// - Setup bit 22 enables the converter self-check.
// - Setup bits 21-18 enable current diagnostics on inputs 3 to 0.
// - Setup bit 17 requests a supply measurement at each polling cycle end.
// - Bit 16 clear lets thermal warning cut high sink currents to 2 mA.
// - Bit 13 clear lets thermal warning cut high source currents to 2 mA.
// - Bits 15-14 set debounce: 1, 2, 3 or 4 equal samples needed.
// - Setup register at 1Ah, read/write, resets to zero.
// - Diagnosis and supply word at 16h, resets to zero.
// - Run bit starts operation, clearing it returns to idle.
// - Poll bit chooses continuous or polling operation.
module smrc_regs
  import smrc_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  ce,
  // Serial register port, pins from the controller
  input  wire logic                  spi_sck,
  input  wire logic                  spi_cs_n,
  input  wire logic                  spi_mosi,
  output logic                       spi_miso,
  output logic                       spi_miso_oe_n,
  // Converter results, same clock
  input  wire logic                  last_input_conv_valid,
  input  wire logic [smrc_pkg::SMRC_CW-1:0] last_input_conversion,
  input  wire logic                  second_last_input_conv_valid,
  input  wire logic [smrc_pkg::SMRC_CW-1:0] second_last_input_conversion,
  input  wire logic                  selfcheck_valid,
  input  wire logic [smrc_pkg::SMRC_CW-1:0] converter_selfcheck_value,
  input  wire logic                  supply_valid,
  input  wire logic [smrc_pkg::SMRC_CW-1:0] supply_level_value,
  // Polling sequencer and analog front end
  input  wire logic                  poll_cycle_end,
  input  wire logic                  thermal_warning,
  input  wire logic [smrc_pkg::SMRC_NIN-1:0] current_source_input,
  input  wire logic [smrc_pkg::SMRC_NIN-1:0] high_current_setting,
  input  wire logic                  sample_strobe,
  input  wire logic [smrc_pkg::SMRC_NIN-1:0] raw_sample,
  // Controls toward the front end
  output logic                       supply_divider_select,
  output logic                       converter_selfcheck_enable,
  output logic [3:0]                 current_diag_enable,
  output logic                       supply_meas_request,
  output logic [smrc_pkg::SMRC_NIN-1:0] current_reduce,
  output logic                       run_active,
  output logic                       polling_mode,
  output logic [smrc_pkg::SMRC_NIN-1:0] switch_state
);
  import smrc_pkg::*;

  // Register state
  logic [SMRC_DW-1:0] setup_q;
  logic [SMRC_DW-1:0] upper_pair_q;
  logic [SMRC_DW-1:0] diag_supply_q;

  // Three-stage pin synchronisers: sck, cs_n, mosi
  logic [2:0] pin_in;
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic [2:0] pin_s3_q;
  logic [2:0] pin_stable_q;
  logic [2:0] pin_stable_d;
  assign pin_in = {spi_mosi, spi_cs_n, spi_sck};

  genvar gp;
  generate
    for (gp = 0; gp < 3; gp++) begin : g_pin
      // A change is taken only once stages two and three agree
      assign pin_stable_d[gp] = (pin_s2_q[gp] == pin_s3_q[gp]) ? pin_s3_q[gp] : pin_stable_q[gp];
    end
  endgenerate

  // Synchroniser chain; only stage two reads stage one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 3'h6;
      pin_s2_q <= 3'h6;
      pin_s3_q <= 3'h6;
    end else if (ce) begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // Accepted pin levels; idle levels after reset avoid a false edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_stable_q <= 3'h6;
    end else if (ce) begin
      pin_stable_q <= pin_stable_d;
    end
  end

  // Edge and level decode of the cleaned pins
  wire sck_rise  = pin_stable_d[0] & ~pin_stable_q[0];
  wire sck_fall  = ~pin_stable_d[0] & pin_stable_q[0];
  wire cs_active = ~pin_stable_q[1];
  wire cs_rise   = pin_stable_d[1] & ~pin_stable_q[1];
  wire mosi_bit  = pin_stable_q[2];

  // Frame engine
  smrc_state_t state_q;
  smrc_state_t state_d;
  logic [5:0]  bit_cnt_q;
  logic [31:0] rx_q;
  logic [24:0] tx_q;
  logic        miso_q;

  wire [5:0]  bit_cnt_inc = bit_cnt_q + 6'h01;
  wire [31:0] rx_next     = {rx_q[30:0], mosi_bit};
  wire        hdr_done    = sck_rise && (bit_cnt_inc == SMRC_HDR_LAST);
  wire [5:0]  rd_addr     = rx_next[5:0];
  wire [5:0]  wr_addr     = rx_q[30:25];
  wire        wr_frame    = rx_q[31];
  // Whole frame, write flag and setup address commit the word
  wire        setup_wr    = cs_rise && (state_q == SMRC_DATA) && (bit_cnt_q == SMRC_FRAME_LAST)
                            && wr_frame && (wr_addr == SMRC_OFS_SETUP);

  // Read decode; unmapped offsets answer zero
  wire hit_setup = (rd_addr == SMRC_OFS_SETUP);
  wire hit_diag  = (rd_addr == SMRC_OFS_DIAG_SUPPLY);
  wire hit_upper = (rd_addr == SMRC_OFS_UPPER_PAIR);
  wire [SMRC_DW-1:0] rd_data =
      hit_setup ? setup_q :
      hit_diag  ? diag_supply_q :
      hit_upper ? upper_pair_q :
                  {SMRC_DW{1'b0}};

  // Next state of the frame engine
  always_comb begin
    state_d = state_q;
    case (state_q)
      SMRC_IDLE: if (cs_active) state_d = SMRC_HDR;
      SMRC_HDR: begin
        if (!cs_active) state_d = SMRC_IDLE;
        else if (hdr_done) state_d = SMRC_DATA;
      end
      SMRC_DATA: if (!cs_active) state_d = SMRC_IDLE;
      default: state_d = SMRC_IDLE;
    endcase
  end

  // Frame engine state; a deselect always returns it to idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SMRC_IDLE;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // Rising clock count, saturating so the commit test sees the frame end
  wire [5:0] bit_cnt_d = (bit_cnt_q == SMRC_FRAME_LAST) ? bit_cnt_q : bit_cnt_inc;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_q <= 6'h00;
    end else if (ce) begin
      if (!cs_active) begin
        bit_cnt_q <= 6'h00;
      end else if (sck_rise) begin
        bit_cnt_q <= bit_cnt_d;
      end
    end
  end

  // Receive shift register, sampled on rising serial clock, MSB first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_q <= 32'h00000000;
    end else if (ce && cs_active && sck_rise) begin
      rx_q <= rx_next;
    end
  end

  // Transmit word loads after the header and shifts on falling serial clock
  wire tx_shift = cs_active && sck_fall && (state_q == SMRC_DATA);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_q <= 25'h0000000;
    end else if (ce && cs_active) begin
      if (hdr_done) begin
        tx_q <= {rd_data, 1'b0};
      end else if (tx_shift) begin
        tx_q <= {tx_q[23:0], 1'b0};
      end
    end
  end

  // Data pin register; parks low while deselected so no stale bit lingers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      miso_q <= 1'b0;
    end else if (ce) begin
      if (!cs_active) begin
        miso_q <= 1'b0;
      end else if (tx_shift && !hdr_done) begin
        miso_q <= tx_q[24];
      end
    end
  end

  // Driven only while selected; the enable is low while driving
  assign spi_miso      = miso_q;
  assign spi_miso_oe_n = ~cs_active;

  // Setup register, full width read/write, zero after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      setup_q <= SMRC_SETUP_RST;
    end else if (ce && setup_wr) begin
      setup_q <= rx_q[24:1];
    end
  end

  // Field decode of the setup register
  wire [1:0] debounce_depth             = setup_q[SMRC_B_FILT_HI:SMRC_B_FILT_LO];
  wire       sink_thermal_cut_disable   = setup_q[SMRC_B_SINKCUT];
  wire       source_thermal_cut_disable = setup_q[SMRC_B_SRCCUT];
  wire       supply_sample_enable       = setup_q[SMRC_B_SUPPLY];

  assign supply_divider_select      = setup_q[SMRC_B_DIV];
  assign converter_selfcheck_enable = setup_q[SMRC_B_SELF] & run_active;
  assign current_diag_enable        = setup_q[SMRC_B_WDIAG3:SMRC_B_WDIAG0];
  assign run_active                 = setup_q[SMRC_B_RUN];
  assign polling_mode               = setup_q[SMRC_B_POLL];

  // Polling cycles exist only while running in a polling mode
  wire poll_cycle_ok = poll_cycle_end & run_active & polling_mode;
  assign supply_meas_request = poll_cycle_ok & supply_sample_enable;

  // Thermal cut per input; current_source_input decides sink or source side
  genvar gi;
  generate
    for (gi = 0; gi < SMRC_NIN; gi++) begin : g_cut
      assign current_reduce[gi] = thermal_warning & run_active & high_current_setting[gi] &
          (current_source_input[gi] ? ~source_thermal_cut_disable
                                    : ~sink_thermal_cut_disable);
    end
  endgenerate

  // Capture strobes; self-check and supply only when their feature is on
  wire selfcheck_take = selfcheck_valid & converter_selfcheck_enable;
  wire supply_take    = supply_valid & supply_sample_enable;

  // Upper input pair, written whenever the converter offers a value
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      upper_pair_q <= SMRC_RESULT_RST;
    end else if (ce) begin
      upper_pair_q[23:20] <= 4'h0;
      if (last_input_conv_valid) begin
        upper_pair_q[SMRC_HI_LSB +: SMRC_CW] <= last_input_conversion;
      end
      if (second_last_input_conv_valid) begin
        upper_pair_q[SMRC_LO_LSB +: SMRC_CW] <= second_last_input_conversion;
      end
    end
  end

  // Diagnosis and supply word; a stale value stays until a new capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      diag_supply_q <= SMRC_RESULT_RST;
    end else if (ce) begin
      diag_supply_q[23:20] <= 4'h0;
      if (selfcheck_take) begin
        diag_supply_q[SMRC_HI_LSB +: SMRC_CW] <= converter_selfcheck_value;
      end
      if (supply_take) begin
        diag_supply_q[SMRC_LO_LSB +: SMRC_CW] <= supply_level_value;
      end
    end
  end

  // Debounce per input: count equal consecutive samples, saturating at three
  generate
    for (gi = 0; gi < SMRC_NIN; gi++) begin : g_deb
      logic       eq_cnt_q;
      logic       last_q;
      logic       state_in_q;
      logic [1:0] cnt_q;
      wire        same   = (raw_sample[gi] == last_q);
      wire        at_max = (cnt_q == 2'h3);
      wire [1:0]  cnt_d  = !same ? 2'h0 : (at_max ? 2'h3 : cnt_q + 2'h1);
      // Code n needs n+1 equal samples, so code zero takes every sample
      wire        accept = (cnt_d >= debounce_depth);
      wire        take   = ce && sample_strobe && run_active;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          cnt_q      <= 2'h0;
          last_q     <= 1'b0;
          state_in_q <= 1'b0;
        end else if (take) begin
          cnt_q  <= cnt_d;
          last_q <= raw_sample[gi];
          if (accept) begin
            state_in_q <= raw_sample[gi];
          end
        end
      end
      assign eq_cnt_q = at_max;
      assign switch_state[gi] = state_in_q;
    end
  endgenerate
endmodule
`default_nettype wire

// ---- rtl/smrc_pkg.sv ----
package smrc_pkg;
  // Register map and frame layout
  localparam logic [5:0] SMRC_OFS_UPPER_PAIR  = 6'h15;
  localparam logic [5:0] SMRC_OFS_DIAG_SUPPLY = 6'h16;
  localparam logic [5:0] SMRC_OFS_SETUP       = 6'h1a;
  localparam logic [23:0] SMRC_SETUP_RST      = 24'h000000;
  localparam logic [23:0] SMRC_RESULT_RST     = 24'h000000;
  localparam int SMRC_DW        = 24;
  localparam int SMRC_CW        = 10;
  localparam int SMRC_NIN       = 24;
  localparam int SMRC_FRAME     = 32;
  localparam int SMRC_HDR_BITS  = 7;
  localparam logic [5:0] SMRC_FRAME_LAST = 6'h20;
  localparam logic [5:0] SMRC_HDR_LAST   = 6'h07;
  // Result word field positions
  localparam int SMRC_HI_LSB    = 10;
  localparam int SMRC_LO_LSB    = 0;
  // Setup register bit positions
  localparam int SMRC_B_DIV     = 23;
  localparam int SMRC_B_SELF    = 22;
  localparam int SMRC_B_WDIAG3  = 21;
  localparam int SMRC_B_WDIAG0  = 18;
  localparam int SMRC_B_SUPPLY  = 17;
  localparam int SMRC_B_SINKCUT = 16;
  localparam int SMRC_B_FILT_HI = 15;
  localparam int SMRC_B_FILT_LO = 14;
  localparam int SMRC_B_SRCCUT  = 13;
  localparam int SMRC_B_RUN     = 11;
  localparam int SMRC_B_POLL    = 10;
  typedef enum logic [2:0] {
    SMRC_IDLE = 3'b001,
    SMRC_HDR  = 3'b010,
    SMRC_DATA = 3'b100
  } smrc_state_t;
endpackage

// ---- bench/smrc_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
// Pin-level checks on the register block
module smrc_monitor (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        spi_cs_n,
  input wire logic        spi_miso,
  input wire logic        spi_miso_oe_n,
  input wire logic        poll_cycle_end,
  input wire logic        thermal_warning,
  input wire logic [23:0] high_current_setting,
  input wire logic        sample_strobe,
  input wire logic        supply_divider_select,
  input wire logic        converter_selfcheck_enable,
  input wire logic        supply_meas_request,
  input wire logic [23:0] current_reduce,
  input wire logic        run_active,
  input wire logic        polling_mode,
  input wire logic [23:0] switch_state
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Front-end controls only follow their enables
  property p_meas; supply_meas_request |-> poll_cycle_end && polling_mode && run_active; endproperty
  a_meas: assert property (p_meas) else $error("supply request without cause");
  property p_self; converter_selfcheck_enable |-> run_active; endproperty
  a_self: assert property (p_self) else $error("self-check on while idle");
  property p_idle; !run_active |-> current_reduce == 24'h0 && !supply_meas_request; endproperty
  a_idle: assert property (p_idle) else $error("activity while idle");
  property p_warm; !thermal_warning |-> current_reduce == 24'h0; endproperty
  a_warm: assert property (p_warm) else $error("current cut without warning");
  property p_high; (current_reduce & ~high_current_setting) == 24'h0; endproperty
  a_high: assert property (p_high) else $error("current cut on low setting");
  // Setup only commits after the frame ends, never mid-frame
  property p_hold; !spi_cs_n [*6] |=> $stable({supply_divider_select, run_active, polling_mode}); endproperty
  a_hold: assert property (p_hold) else $error("setup moved inside a frame");
  property p_off; spi_cs_n [*5] |-> spi_miso_oe_n && !spi_miso; endproperty
  a_off: assert property (p_off) else $error("data pin driven while deselected");
  property p_sw; $changed(switch_state) |-> $past(sample_strobe) && $past(run_active); endproperty
  a_sw: assert property (p_sw) else $error("switch state moved without sample");
endmodule
`default_nettype wire

// ---- bench/smrc_spi_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// Controller end of the serial port: mode 0, most significant bit first
module smrc_spi_host (
  input  wire logic clk,
  output logic      sck,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  initial {sck, cs_n, mosi} = 3'b010;
  // Eight clocks per half period keep each pin edge clear of the synchroniser
  task automatic xfer(input logic [31:0] f, output logic [23:0] q);
    q = 24'h0;
    @(posedge clk) cs_n <= 1'b0;
    for (int k = 31; k >= 0; k--) begin
      mosi <= f[k];
      repeat (8) @(posedge clk);
      if (k > 0 && k < 25) q = {q[22:0], miso};
      sck <= 1'b1;
      repeat (8) @(posedge clk);
      sck <= 1'b0;
    end
    mosi <= ~f[0]; // Released line shows no stale level
    repeat (8) @(posedge clk);
    cs_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ---- bench/switch_monitor_result_config_regs_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module switch_monitor_result_config_regs_tb;
  import smrc_pkg::*;
  logic        clk, rst_n, ce, spi_sck, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n, poll_cycle_end, thermal_warning;
  logic        last_input_conv_valid, second_last_input_conv_valid, selfcheck_valid, supply_valid, sample_strobe;
  logic        supply_divider_select, converter_selfcheck_enable, supply_meas_request, run_active, polling_mode;
  logic [9:0]  last_input_conversion, second_last_input_conversion, converter_selfcheck_value, supply_level_value;
  logic [23:0] current_source_input, high_current_setting, raw_sample, current_reduce, switch_state;
  logic [3:0]  current_diag_enable;
  logic [31:0] lf;
  int          error_cnt, samples_checked, setup_m, sw_m;
  smrc_regs i_dut (.*);
  smrc_spi_host i_host (.clk(clk), .sck(spi_sck), .cs_n(spi_cs_n), .mosi(spi_mosi), .miso(spi_miso));
  // 25 MHz system clock
  always #20 clk = ~clk;
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // One frame; on a read the data word is the expected answer
  task automatic acc(input logic w, input logic [5:0] a, input logic [23:0] d);
    logic [23:0] q;
    i_host.xfer({w, a, d, 1'b0}, q);
    if (!w) chk(q, d);
  endtask
  task automatic cfg(input logic [23:0] v);
    acc(1'b1, SMRC_OFS_SETUP, v & 24'hfff7ff);
    acc(1'b1, SMRC_OFS_SETUP, v);
    setup_m = v;
  endtask
  // Hang guard, well beyond the thirty-four frames used
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    summarize();
  end
  initial begin
    {clk, rst_n, ce, lf} = {3'b001, 32'd95911};
    {last_input_conv_valid, second_last_input_conv_valid, selfcheck_valid, supply_valid, sample_strobe} = '0;
    {last_input_conversion, second_last_input_conversion, converter_selfcheck_value, supply_level_value} = '0;
    {poll_cycle_end, thermal_warning, current_source_input, high_current_setting, raw_sample} = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    acc(1'b0, SMRC_OFS_DIAG_SUPPLY, 24'h0);
    acc(1'b0, SMRC_OFS_SETUP, 24'h0);
    // Random setup with run off; a read-only word must ignore writes
    lf = nxt(lf);
    cfg(lf[23:0] & 24'hfff7ff);
    acc(1'b1, SMRC_OFS_DIAG_SUPPLY, 24'hffffff);
    acc(1'b0, SMRC_OFS_SETUP, 24'(setup_m));
    acc(1'b0, SMRC_OFS_DIAG_SUPPLY, 24'h0);
    acc(1'b0, 6'h3f, 24'h0);
    chk({supply_divider_select, converter_selfcheck_enable, current_diag_enable}, setup_m[23:18] & 6'h2f);
    chk(polling_mode, setup_m[10]);
    // Results with capture gating off, then self-check and supply sampling on
    for (int r = 0; r < 2; r++) begin
      cfg(r ? 24'h420800 : 24'h0);
      lf = nxt(lf);
      @(posedge clk);
      {last_input_conversion, second_last_input_conversion, converter_selfcheck_value} <= lf[29:0];
      supply_level_value <= lf[31:22];
      {last_input_conv_valid, second_last_input_conv_valid, selfcheck_valid, supply_valid} <= 4'hf;
      @(posedge clk);
      {last_input_conv_valid, second_last_input_conv_valid, selfcheck_valid, supply_valid} <= 4'h0;
      acc(1'b0, SMRC_OFS_UPPER_PAIR, {4'h0, lf[29:10]});
      acc(1'b0, SMRC_OFS_DIAG_SUPPLY, r ? {4'h0, lf[9:0], lf[31:22]} : 24'h0);
      chk(converter_selfcheck_enable, 24'(r));
      chk(run_active, 24'(r));
    end
    // All four mixes of the sink and source cut-disable bits
    for (int c = 0; c < 4; c++) begin
      cfg({6'h0, c[0] ^ c[1], c[0], 2'b00, c[1], 3'b011, 10'h0});
      lf = nxt(lf);
      @(posedge clk);
      {poll_cycle_end, thermal_warning, current_source_input, high_current_setting} <= {2'b11, lf[23:0], lf[31:8]};
      @(negedge clk);
      chk(supply_meas_request, 24'(c[0] ^ c[1]));
      chk(current_reduce, lf[31:8] & (lf[23:0] & {24{~c[1]}} | ~lf[23:0] & {24{~c[0]}}));
      @(posedge clk);
      {poll_cycle_end, thermal_warning} <= 2'b00;
    end
    // Each filter depth: new pattern shows only after depth plus one equal samples
    for (int c = 0; c < 4; c++) begin
      cfg({8'h0, c[1:0], 14'h0800});
      lf = nxt(lf);
      for (int i = 1; i < 5; i++) begin
        @(posedge clk);
        {sample_strobe, raw_sample} <= {1'b1, lf[23:0]};
        @(posedge clk);
        sample_strobe <= 1'b0;
        @(negedge clk);
        chk(switch_state, i > c ? lf[23:0] : 24'(sw_m));
      end
      sw_m = lf[23:0];
    end
    // Clock enable low freezes the filter; a second strobe lands once it is high
    cfg(24'h000800);
    for (int e = 0; e < 2; e++) begin
      @(posedge clk);
      {ce, sample_strobe, raw_sample} <= {e[0], 1'b1, ~lf[23:0]};
      @(posedge clk);
      {ce, sample_strobe} <= 2'b10;
      @(negedge clk);
      chk(switch_state, e ? ~lf[23:0] : 24'(sw_m));
    end
    summarize();
  end
endmodule
bind smrc_regs smrc_monitor i_mon (.*);
`default_nettype wire
